//--- bench/sfd_top_tb.sv
// self-checking bench for the supply fault detector logic
`timescale 1ns/1ps
module sfd_top_tb import sfd_pkg::*; ();
	// ==========================================
	// bench signals
	localparam int CPU = 2; // cycles per microsecond, kept short so filter runs stay brief
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr;
	logic psel, penable, pwrite;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic [NCH*CODE_W-1:0] chan_level; // per-channel level codes
	logic [NVX-1:0] dual_use_input;
	logic [NCH-1:0] fault;
	logic [2*NCH-1:0] range_sel;
	logic [NVX-1:0] logic_in;
	logic irq;
	int err_total, checks_done, n, d0, d2;
	logic [31:0] seed = 32'h1718; // fixed start keeps runs repeatable
	logic [31:0] rd, w; // last read data, scratch config word
	logic er; // last error response
	// ==========================================
	// clock and device
	always #2.5 pclk = ~pclk;
	sfd_top #(.CYC_PER_US(CPU)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan_level(chan_level), .dual_use_input(dual_use_input), .fault(fault),
		.range_sel(range_sel), .logic_in(logic_in), .irq(irq));
	// ==========================================
	// helpers
	// next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected config word from its fields
	function automatic logic [31:0] cfgw(input logic [7:0] uv, input logic [7:0] ov, input logic [4:0] hy,
		input logic [1:0] md, input logic [1:0] rg, input logic [6:0] gf);
		return {gf, rg, md, hy, ov, uv};
	endfunction
	// a legal range for each channel
	function automatic logic [1:0] rg(input int ch);
		return (ch == 0) ? RNG_8V4 : (ch < 4) ? RNG_3V5 : RNG_0V8;
	endfunction
	// verdict, reached from the main sequence or a timeout
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// the single value comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			err_total++;
			$display("BAD t=%0t no apb answer", $time);
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// set one channel level right after an edge
	task automatic lv(input int ch, input logic [7:0] v);
		@(posedge pclk);
		chan_level[8*ch +: 8] <= v;
	endtask
	// wait, bounded, for a fault output to reach a value; c gives the cycles taken
	task automatic wf(input int ch, input logic v, output int c);
		for (c = 1; c < 400; c++) begin
			@(posedge pclk);
			if (fault[ch] === v) begin
				checks_done++;
				return;
			end
		end
		err_total++;
		$display("BAD t=%0t fault wait ran out", $time);
		final_report();
	endtask
	// fault output must keep a value for c cycles
	task automatic hold(input int ch, input logic v, input int c);
		repeat (c) begin
			@(posedge pclk);
			chk({31'h0, fault[ch]}, {31'h0, v});
		end
	endtask
	// ==========================================
	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		$display("BAD t=%0t run limit reached", $time);
		final_report();
	end
	// ==========================================
	// main sequence
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		chan_level = '0;
		dual_use_input = 4'h0;
		err_total = 0;
		checks_done = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk({16'h0, range_sel}, 32'h0000_0002);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h60, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFF_STATUS, 32'hffff_ffff);
		chk({31'h0, er}, 32'h0);
		// random config words read back whole, range mirrored on the pins
		for (int ch = 0; ch < NCH; ch++) begin
			seed = lfsr(seed);
			w = cfgw(seed[7:0], seed[15:8], seed[20:16], seed[22:21], rg(ch), seed[31:25] % 7'd101);
			apb(1'b1, 8'h40 + {ch[5:0], 2'b00}, w);
			apb(1'b0, 8'h40 + {ch[5:0], 2'b00}, 32'h0);
			chk(rd, w);
			chk({30'h0, range_sel[2*ch +: 2]}, {30'h0, rg(ch)});
		end
		// a range the input lacks is refused; an oversize timeout is clamped
		apb(1'b1, 8'h44, cfgw(8'h00, 8'h00, 5'h00, MODE_OFF, RNG_8V4, 7'h7f));
		apb(1'b0, 8'h44, 32'h0);
		chk(rd, cfgw(8'h00, 8'h00, 5'h00, MODE_OFF, RNG_3V5, GF_MAX_US));
		// ==========================================
		// window mode trips on either side
		apb(1'b1, 8'h44, cfgw(8'h40, 8'hc0, 5'h00, MODE_WIN, RNG_1V75, 7'h00));
		lv(1, 8'h80);
		wf(1, 1'b0, n);
		lv(1, 8'h30);
		wf(1, 1'b1, n);
		lv(1, 8'h80);
		wf(1, 1'b0, n);
		lv(1, 8'hd0);
		wf(1, 1'b1, n);
		lv(1, 8'h80);
		wf(1, 1'b0, n);
		// undervoltage: no hysteresis before the trip, hysteresis after it
		apb(1'b1, 8'h44, cfgw(8'h80, 8'hff, 5'h04, MODE_UV, RNG_1V75, 7'h00));
		hold(1, 1'b0, 12);
		lv(1, 8'h7f);
		wf(1, 1'b1, n);
		lv(1, 8'h84);
		hold(1, 1'b1, 12);
		lv(1, 8'h85);
		wf(1, 1'b0, n);
		// overvoltage: release only below threshold minus hysteresis
		// at the old undervoltage threshold: trips neither old nor new setting
		lv(1, 8'h80);
		apb(1'b1, 8'h44, cfgw(8'h00, 8'h80, 5'h04, MODE_OV, RNG_1V75, 7'h00));
		hold(1, 1'b0, 8);
		lv(1, 8'h81);
		wf(1, 1'b1, n);
		lv(1, 8'h7c);
		hold(1, 1'b1, 12);
		lv(1, 8'h7b);
		wf(1, 1'b0, n);
		// ==========================================
		// interrupt: sticky, masked, cleared by a one
		apb(1'b0, OFF_INT_STAT, 32'h0);
		chk({31'h0, rd[1]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFF_INT_MASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFF_INT_STAT, 32'hff);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		lv(1, 8'h81);
		wf(1, 1'b1, n);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		// ==========================================
		// glitch filter: delay grows by the timeout, short pulses vanish
		apb(1'b1, 8'h44, cfgw(8'h80, 8'hff, 5'h00, MODE_UV, RNG_1V75, 7'h00));
		lv(1, 8'h90);
		wf(1, 1'b0, n);
		lv(1, 8'h10);
		wf(1, 1'b1, d0);
		lv(1, 8'h90);
		wf(1, 1'b0, n);
		apb(1'b1, 8'h44, cfgw(8'h80, 8'hff, 5'h00, MODE_UV, RNG_1V75, 7'h02));
		lv(1, 8'h10);
		wf(1, 1'b1, d2);
		chk(32'(d2 - d0), 32'(2 * CPU));
		lv(1, 8'h90);
		wf(1, 1'b0, n);
		lv(1, 8'h10);
		repeat (3) @(posedge pclk);
		lv(1, 8'h90);
		hold(1, 1'b0, 20);
		lv(1, 8'h10);
		repeat (5) @(posedge pclk);
		lv(1, 8'h90);
		wf(1, 1'b1, n);
		// mode off: a low level raises nothing
		apb(1'b1, 8'h44, cfgw(8'h80, 8'hff, 5'h00, MODE_OFF, RNG_1V75, 7'h00));
		wf(1, 1'b0, n);
		lv(1, 8'h10);
		hold(1, 1'b0, 10);
		// ==========================================
		// dual-use channel: logic input or detector, never both
		apb(1'b1, 8'h50, cfgw(8'h80, 8'hff, 5'h00, MODE_UV, RNG_0V8, 7'h00));
		lv(4, 8'h10);
		seed = lfsr(seed);
		@(posedge pclk);
		dual_use_input <= seed[3:0];
		repeat (4) @(posedge pclk);
		chk({28'h0, logic_in}, {28'h0, seed[3:0]});
		hold(4, 1'b0, 10);
		apb(1'b1, OFF_CTRL, 32'h1);
		wf(4, 1'b1, n);
		repeat (4) @(posedge pclk);
		chk({31'h0, logic_in[0]}, 32'h0);
		// status word: filtered and raw faults of ch4 only, logic inputs of ch5-7
		apb(1'b0, OFF_STATUS, 32'h0);
		chk({28'h0, rd[7:4]}, 32'h1);
		chk({28'h0, rd[15:12]}, 32'h1);
		chk({28'h0, rd[19:16]}, {28'h0, seed[3:1], 1'b0});
		final_report();
	end
endmodule

//--- design/sfd_glitch.sv
// glitch filter for one supply fault detector channel
`timescale 1ns/1ps
module sfd_glitch import sfd_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// comparator in, timeout in cycles
	input wire logic raw,
	input wire logic [CNT_W-1:0] tgt,
	// filtered fault
	output logic filt
);
	// ==========================================
	// state
	typedef struct packed {
		logic [CNT_W-1:0] cnt; // cycles the input has differed
		logic out; // filtered level
	} sfd_glitch_state_type;
	sfd_glitch_state_type s_q, s_d;

	// ==========================================
	// next state: restart on agreement, pass when count reached
	always_comb begin
		s_d = s_q;
		if (raw == s_q.out) begin
			s_d.cnt = '0; // RULE14
		end else if (s_q.cnt >= tgt) begin
			// level held long enough: pass it, delayed by timeout
			s_d.out = raw; // RULE12 RULE13
			s_d.cnt = '0;
		end else begin
			// short pulses die here, output unchanged
			s_d.cnt = s_q.cnt + 1'b1; // RULE11
		end
	end

	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign filt = s_q.out;

	// ==========================================
	// checks
	property p_gf_block;
		@(posedge pclk) disable iff (!presetn)
		(raw != s_q.out && s_q.cnt < tgt) |=> s_q.out == $past(s_q.out);
	endproperty
	a_gf_block: assert property (p_gf_block) else $error("glitch passed early"); // RULE11

	property p_gf_pass;
		@(posedge pclk) disable iff (!presetn)
		(raw != s_q.out && s_q.cnt >= tgt) |=> s_q.out == $past(raw);
	endproperty
	a_gf_pass: assert property (p_gf_pass) else $error("held level not passed"); // RULE12

	property p_gf_restart;
		@(posedge pclk) disable iff (!presetn)
		(raw == s_q.out) |=> s_q.cnt == '0;
	endproperty
	a_gf_restart: assert property (p_gf_restart) else $error("counter not restarted"); // RULE14
endmodule

//--- design/sfd_pkg.sv
// constants, field layouts and types shared by the supply fault detector logic
package sfd_pkg;
	// ==========================================
	// channel layout
	localparam int NCH = 8; // ch0 high range, ch1-3 low range, ch4-7 dual use
	localparam int NVX = 4; // dual-use channels
	localparam int VX_BASE = 4; // first dual-use channel
	localparam int CODE_W = 8; // threshold and level code width
	localparam int HYST_W = 5; // hysteresis_code width
	localparam int GF_W = 7; // glitch timeout field, microseconds
	// ==========================================
	// apb register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_INT_STAT = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0c;
	localparam logic [2:0] CFG_BASE_HI = 3'h2; // cfg block at 0x40..0x5c
	// ==========================================
	// channel config word fields
	localparam int UV_LSB = 0;
	localparam int OV_LSB = 8;
	localparam int HY_LSB = 16;
	localparam int MODE_LSB = 21;
	localparam int RNG_LSB = 23;
	localparam int GF_LSB = 25;
	// status word fields
	localparam int ST_FLT_LSB = 0;
	localparam int ST_RAW_LSB = 8;
	localparam int ST_DIN_LSB = 16;
	// ==========================================
	// timing: longest glitch timeout and clock rate
	localparam logic [GF_W-1:0] GF_MAX_US = 7'h64; // 100 us
	localparam int CLK_MHZ = 200;
	localparam int CYC_PER_US_DEF = CLK_MHZ * 1; // cycles in 1 us
	localparam int CNT_W = 15; // holds 100 us of cycles
	// ==========================================
	// detection mode of a channel
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_UV = 2'b01,
		MODE_OV = 2'b10,
		MODE_WIN = 2'b11
	} sfd_mode_type;
	// input range, by span: 0.802, 1.75, 3.5 and 8.4 volts
	localparam logic [1:0] RNG_0V8 = 2'b00;
	localparam logic [1:0] RNG_1V75 = 2'b01;
	localparam logic [1:0] RNG_3V5 = 2'b10;
	localparam logic [1:0] RNG_8V4 = 2'b11;
	// ==========================================
	// whole state of the top module
	typedef struct packed {
		logic [NCH-1:0][CODE_W-1:0] lvl1; // level sync stage 1
		logic [NCH-1:0][CODE_W-1:0] lvl2; // level sync stage 2
		logic [NVX-1:0] din1; // logic input sync stage 1
		logic [NVX-1:0] din2; // logic input sync stage 2
		logic [NCH-1:0][31:0] cfg; // per-channel config words
		logic [NVX-1:0] aen; // dual-use channel set to analog
		logic [NCH-1:0] uv; // undervoltage comparator with hysteresis
		logic [NCH-1:0] ov; // overvoltage comparator with hysteresis
		logic [NCH-1:0] comp; // selected comparator result
		logic [NCH-1:0] flt_d1; // filtered fault, last cycle
		logic [NCH-1:0] ist; // sticky fault-raised flags
		logic [NCH-1:0] imask; // interrupt enables
		logic [NVX-1:0] dout; // logic input results
		logic [2*NCH-1:0] rng; // range selects to attenuators
		logic [31:0] rdata;
		logic rdy;
		logic err;
		logic irq;
	} sfd_state_type;
endpackage

//--- design/sfd_top.sv
// eight-channel supply fault detector logic with apb registers
// Functional notes
// RULE1: eight channels; dual-use analog excludes logic input
// RULE2: modes undervoltage, overvoltage or out-of-window
// RULE3: 8-bit unsigned thresholds in writable config
// RULE4: code n trips at bottom plus span*n/255
// RULE5: per-channel range; legal ranges depend on input
// RULE6: 5-bit hysteresis code scales span*code/255
// RULE7: hysteresis applies only once a fault raised
// RULE8: undervoltage holds until above threshold plus hysteresis
// RULE9: overvoltage holds until below threshold minus hysteresis
// RULE10: glitch filter timeout programmable 0 to 100us
// RULE11: pulses shorter than timeout are blocked
// RULE12: pulses longer than timeout pass through
// RULE13: passed transitions delayed by the timeout
// RULE14: counter restarts on change, passes at count
// RULE15: window fault is undervoltage OR overvoltage
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module sfd_top import sfd_pkg::*; #(
	parameter int CYC_PER_US = CYC_PER_US_DEF // clock cycles per microsecond
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// digitised channel levels, code scale of the selected range
	input wire logic [NCH*CODE_W-1:0] chan_level,
	// dual_use_input pins seen as logic levels
	input wire logic [NVX-1:0] dual_use_input,
	// results
	output logic [NCH-1:0] fault,
	output logic [2*NCH-1:0] range_sel,
	output logic [NVX-1:0] logic_in,
	output logic irq
);
	// ==========================================
	// state and wires
	sfd_state_type s_q, s_d;
	logic [NCH-1:0] filt; // glitch filter outputs
	logic [NCH-1:0][CNT_W-1:0] tgt; // glitch timeouts in cycles

	// range legality per input kind
	function automatic logic rng_ok(input int ch, input logic [1:0] r);
		logic ok;
		ok = 1'b0;
		if (ch == 0) begin
			// high_range_input: two upper ranges
			ok = (r == RNG_3V5) || (r == RNG_8V4); // RULE5
		end else if (ch < VX_BASE) begin
			// low_range_input: three lower ranges
			ok = (r != RNG_8V4); // RULE5
		end else begin
			// dual_use_input: lowest range only
			ok = (r == RNG_0V8); // RULE5
		end
		return ok;
	endfunction

	// ==========================================
	// glitch filters, one per channel
	genvar g;
	for (g = 0; g < NCH; g++) begin : g_flt
		// timeout in microseconds scaled to cycles
		assign tgt[g] = CNT_W'(s_q.cfg[g][GF_LSB+:GF_W] * CYC_PER_US); // RULE10
		sfd_glitch u_flt (
			.pclk(pclk),
			.presetn(presetn),
			.raw(s_q.comp[g]),
			.tgt(tgt[g]),
			.filt(filt[g])
		);
	end

	// ==========================================
	// next-state logic: synchronisers, comparators, apb, interrupts
	always_comb begin
		logic [CODE_W-1:0] lv; // level code of the channel
		logic [CODE_W-1:0] uth; // undervoltage threshold code
		logic [CODE_W-1:0] oth; // overvoltage threshold code
		logic [HYST_W-1:0] hy; // hysteresis_code
		logic [CODE_W:0] up; // undervoltage release point
		logic act; // channel is doing analog detection
		logic acc; // apb access completes this edge
		logic bad; // unmapped address
		logic [2:0] ix; // config word index
		logic [31:0] wv; // write value for a config word
		logic [NCH-1:0] rise; // newly raised faults
		lv = '0;
		uth = '0;
		oth = '0;
		hy = '0;
		up = '0;
		act = 1'b0;
		acc = 1'b0;
		bad = 1'b0;
		ix = '0;
		wv = '0;
		rise = '0;
		s_d = s_q;

		// two flops on the channel levels and the dual-use pins
		s_d.lvl1 = chan_level;
		s_d.lvl2 = s_q.lvl1;
		s_d.din1 = dual_use_input;
		s_d.din2 = s_q.din1;

		// comparators work in code space: code n is bottom + span*n/255,
		// so hysteresis codes add directly to threshold codes
		for (int i = 0; i < NCH; i++) begin
			lv = s_q.lvl2[i];
			uth = s_q.cfg[i][UV_LSB+:CODE_W]; // RULE3
			oth = s_q.cfg[i][OV_LSB+:CODE_W]; // RULE3
			hy = s_q.cfg[i][HY_LSB+:HYST_W]; // RULE6
			up = {1'b0, uth} + {4'h0, hy};
			// truncated index stays in range for the dedicated channels too
			act = (i < VX_BASE) || s_q.aen[2'(i - VX_BASE)]; // RULE1
			if (!act) begin
				// logic-input channel: no fault detection
				s_d.uv[i] = 1'b0; // RULE1
				s_d.ov[i] = 1'b0;
			end else begin
				if (!s_q.uv[i]) begin
					// in tolerance: plain threshold, no hysteresis yet
					s_d.uv[i] = lv < uth; // RULE4 RULE7
				end else begin
					// raised: release only above threshold plus hysteresis
					s_d.uv[i] = !({1'b0, lv} > up); // RULE8
				end
				if (!s_q.ov[i]) begin
					s_d.ov[i] = lv > oth; // RULE4 RULE7
				end else begin
					// release only below threshold minus hysteresis;
					// with hysteresis above threshold it never releases
					s_d.ov[i] = !(({1'b0, lv} + {4'h0, hy}) < {1'b0, oth}); // RULE9
				end
			end
			// pick the result that feeds the glitch filter
			unique case (sfd_mode_type'(s_q.cfg[i][MODE_LSB+:2]))
				MODE_OFF: s_d.comp[i] = 1'b0;
				MODE_UV: s_d.comp[i] = s_d.uv[i]; // RULE2
				MODE_OV: s_d.comp[i] = s_d.ov[i]; // RULE2
				MODE_WIN: s_d.comp[i] = s_d.uv[i] | s_d.ov[i]; // RULE2 RULE15
			endcase
			s_d.rng[2*i+:2] = s_q.cfg[i][RNG_LSB+:2];
		end

		// logic inputs read as zero while the pin does analog work
		for (int k = 0; k < NVX; k++) begin
			s_d.dout[k] = s_q.din2[k] & ~s_q.aen[k]; // RULE1
		end

		// fault-raised events
		s_d.flt_d1 = filt;
		rise = filt & ~s_q.flt_d1;

		// ----- apb: pready one cycle into the access phase -----
		s_d.rdy = psel & penable & ~s_q.rdy;
		acc = psel & penable & s_q.rdy;
		ix = paddr[4:2];
		bad = (paddr[1:0] != 2'b00);
		if (paddr[7:5] != CFG_BASE_HI) begin
			if (paddr != OFF_CTRL && paddr != OFF_STATUS &&
				paddr != OFF_INT_STAT && paddr != OFF_INT_MASK) begin
				bad = 1'b1;
			end
		end
		if (s_d.rdy) begin
			// answer data and error settle with pready
			s_d.err = bad;
			s_d.rdata = '0;
			if (!pwrite && !bad) begin
				if (paddr[7:5] == CFG_BASE_HI) begin
					s_d.rdata = s_q.cfg[ix];
				end else begin
					unique case (paddr)
						OFF_CTRL: s_d.rdata[NVX-1:0] = s_q.aen;
						OFF_STATUS: begin
							s_d.rdata[ST_FLT_LSB+:NCH] = filt;
							s_d.rdata[ST_RAW_LSB+:NCH] = s_q.comp;
							s_d.rdata[ST_DIN_LSB+:NVX] = s_q.dout;
						end
						OFF_INT_STAT: s_d.rdata[NCH-1:0] = s_q.ist;
						OFF_INT_MASK: s_d.rdata[NCH-1:0] = s_q.imask;
						default: s_d.rdata = '0;
					endcase
				end
			end
		end else begin
			s_d.err = 1'b0;
			s_d.rdata = '0;
		end

		// sticky status: an event in the clearing cycle stays set
		s_d.ist = s_q.ist | rise;
		if (acc && pwrite && !bad) begin
			if (paddr[7:5] == CFG_BASE_HI) begin
				wv = pwdata;
				// an illegal range for this input keeps the old one
				if (!rng_ok(int'(ix), pwdata[RNG_LSB+:2])) begin
					wv[RNG_LSB+:2] = s_q.cfg[ix][RNG_LSB+:2]; // RULE5
				end
				// timeouts beyond the longest are held at it
				if (pwdata[GF_LSB+:GF_W] > GF_MAX_US) begin
					wv[GF_LSB+:GF_W] = GF_MAX_US; // RULE10
				end
				s_d.cfg[ix] = wv; // RULE3
			end else begin
				unique case (paddr)
					OFF_CTRL: s_d.aen = pwdata[NVX-1:0];
					OFF_INT_STAT: s_d.ist = (s_q.ist & ~pwdata[NCH-1:0]) | rise;
					OFF_INT_MASK: s_d.imask = pwdata[NCH-1:0];
					default: s_d.aen = s_q.aen; // status is read-only
				endcase
			end
		end
		// level interrupt from unmasked sticky bits
		s_d.irq = |(s_d.ist & s_d.imask);
	end

	// ==========================================
	// register the state; high input defaults to its lower range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.cfg[0][RNG_LSB+:2] <= RNG_3V5; // RULE5
			s_q.rng[1:0] <= RNG_3V5;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs straight from flops
	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign fault = filt;
	assign range_sel = s_q.rng;
	assign logic_in = s_q.dout;
	assign irq = s_q.irq;

	// ==========================================
	// checks on channels 0 and 1, the first dual-use input and the bus
	property p_rng_legal;
		@(posedge pclk) disable iff (!presetn)
		s_q.rng[1:0] == RNG_3V5 || s_q.rng[1:0] == RNG_8V4;
	endproperty
	a_rng_legal: assert property (p_rng_legal) else $error("illegal range on high input"); // RULE5

	property p_vx_logic;
		@(posedge pclk) disable iff (!presetn)
		s_q.aen[0] |=> !s_q.dout[0];
	endproperty
	a_vx_logic: assert property (p_vx_logic) else $error("analog pin used as logic"); // RULE1

	property p_vx_off;
		@(posedge pclk) disable iff (!presetn)
		!s_q.aen[0] |=> !s_q.uv[VX_BASE] && !s_q.ov[VX_BASE];
	endproperty
	a_vx_off: assert property (p_vx_off) else $error("logic pin raised fault"); // RULE1

	property p_uv_set;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.uv[0] && s_q.lvl2[0] < s_q.cfg[0][UV_LSB+:CODE_W]) |=> s_q.uv[0];
	endproperty
	a_uv_set: assert property (p_uv_set) else $error("undervoltage not raised"); // RULE2

	property p_uv_hold;
		@(posedge pclk) disable iff (!presetn)
		(s_q.uv[0] && {1'b0, s_q.lvl2[0]} <=
			{1'b0, s_q.cfg[0][UV_LSB+:CODE_W]} + {4'h0, s_q.cfg[0][HY_LSB+:HYST_W]})
		|=> s_q.uv[0];
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("undervoltage released early"); // RULE8

	property p_ov_hold;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ov[1] && {1'b0, s_q.lvl2[1]} + {4'h0, s_q.cfg[1][HY_LSB+:HYST_W]} >=
			{1'b0, s_q.cfg[1][OV_LSB+:CODE_W]})
		|=> s_q.ov[1];
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("overvoltage released early"); // RULE9

	property p_win;
		@(posedge pclk) disable iff (!presetn)
		(s_q.cfg[1][MODE_LSB+:2] == MODE_WIN && $stable(s_q.cfg[1]))
		|-> s_q.comp[1] == (s_q.uv[1] | s_q.ov[1]);
	endproperty
	a_win: assert property (p_win) else $error("window result wrong"); // RULE15

	property p_gf_max;
		@(posedge pclk) disable iff (!presetn)
		s_q.cfg[0][GF_LSB+:GF_W] <= GF_MAX_US;
	endproperty
	a_gf_max: assert property (p_gf_max) else $error("glitch timeout above limit"); // RULE10

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(filt[1] && !s_q.flt_d1[1] && s_q.imask[1] && $stable(s_q.imask)) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("raised fault gave no interrupt");

	property p_ov_set;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ov[1] && s_q.lvl2[1] > s_q.cfg[1][OV_LSB+:CODE_W]) |=> s_q.ov[1];
	endproperty
	a_ov_set: assert property (p_ov_set) else $error("overvoltage not raised"); // RULE2

	// no hysteresis while in tolerance: at or above threshold stays clear
	property p_uv_quiet;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.uv[1] && s_q.lvl2[1] >= s_q.cfg[1][UV_LSB+:CODE_W]) |=> !s_q.uv[1];
	endproperty
	a_uv_quiet: assert property (p_uv_quiet) else $error("undervoltage raised in tolerance"); // RULE7

	property p_uv_clear;
		@(posedge pclk) disable iff (!presetn)
		(s_q.uv[1] && {1'b0, s_q.lvl2[1]} >
			{1'b0, s_q.cfg[1][UV_LSB+:CODE_W]} + {4'h0, s_q.cfg[1][HY_LSB+:HYST_W]})
		|=> !s_q.uv[1];
	endproperty
	a_uv_clear: assert property (p_uv_clear) else $error("undervoltage not released"); // RULE8

	property p_ov_clear;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ov[1] && {1'b0, s_q.lvl2[1]} + {4'h0, s_q.cfg[1][HY_LSB+:HYST_W]} <
			{1'b0, s_q.cfg[1][OV_LSB+:CODE_W]})
		|=> !s_q.ov[1];
	endproperty
	a_ov_clear: assert property (p_ov_clear) else $error("overvoltage not released"); // RULE9

	// answer pulses: pready one cycle only, error only with it
	property p_rdy_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");

	property p_err_rdy;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without pready");
endmodule
